/* File: hw/smm_pkg.sv */
// Overview of operation
// - opcode 54 shifts the second accumulator right one place, zero into bit 7.
// - after that shift: C=old bit 0, N=0, Z=result zero, V=N xor C.
// - opcode 49 shifts the double accumulator right, zero into bit 15, old bit 0 to C.
// - after the 16-bit shift: N=0, Z=result zero, V=new C.
// - prefix 18 18 keeps the larger of A and memory in A; A loads memory when C=1.
// - max/min flags come from A minus memory: N, Z, overflow, borrow.
// - prefix 18 1C writes the larger value back to memory; A written when C=0.
// - prefix 18 19 keeps the smaller value in A; A loads memory when C=0.
// - max/min operands are reached only through indexed addressing forms.
// - opcode 01 takes the input from A, descriptor from X, destination from Y.
// - descriptor is four bytes at X: start point, end point, leading, trailing slope.
// - a zero slope means infinite slope: that side's grade is FF from its point.
// - after storing the grade: A unchanged, Y plus 1, X plus 4.
// - membership leaves H, N, Z, V and C undefined; only a_fixed_bits checks any of them, that H stays unchanged.
package smm_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_ACC_D = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INDEX_X = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INDEX_Y = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OPER_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h14;
  localparam int CC_S = 7;
  localparam int CC_X = 6;
  localparam int CC_H = 5;
  localparam int CC_I = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  localparam logic [7:0] CC_RST = 8'hd0;
  localparam int CMD_PREFIX_BIT = 8;
  localparam int CMD_MODE_LSB = 9;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam logic [7:0] OPC_SHIFT_B = 8'h54;
  localparam logic [7:0] OPC_SHIFT_D = 8'h49;
  localparam logic [7:0] OPC_GRADE = 8'h01;
  localparam logic [7:0] OPC_MAX_A = 8'h18;
  localparam logic [7:0] OPC_MAX_M = 8'h1c;
  localparam logic [7:0] OPC_MIN_A = 8'h19;
  localparam logic [2:0] MODE_LAST_INDEXED = 3'h4;
  localparam logic [15:0] GRADE_X_STEP = 16'h0004;
  localparam logic [15:0] GRADE_Y_STEP = 16'h0001;
  localparam int DSC_POINT_1 = 0;
  localparam int DSC_POINT_2 = 1;
  localparam int DSC_SLOPE_1 = 2;
  localparam int DSC_SLOPE_2 = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_shift_right_second_acc = 3'b001,
    op_shift_right_double_acc = 3'b010,
    op_max_to_accumulator = 3'b011,
    op_max_to_memory = 3'b100,
    op_min_to_accumulator = 3'b101,
    op_grade_membership = 3'b110
  } op_e;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_read = 3'b001,
    st_write = 3'b010,
    st_desc = 3'b011,
    st_calc = 3'b100
  } state_e;

  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } mem_rsp_s;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } nzvc_s;
endpackage

/* File: hw/right_shifter.sv */
module right_shifter import smm_pkg::*;
(
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  output logic [7:0] b_result,
  output nzvc_s b_flags,
  output logic [15:0] d_result,
  output nzvc_s d_flags
);
  always_comb
  begin
    b_result = {1'b0, acc_b[7:1]};
    b_flags.n = 1'b0;
    b_flags.z = (b_result == 8'h00);
    b_flags.c = acc_b[0];
    b_flags.v = b_flags.n ^ b_flags.c;
    d_result = {1'b0, acc_a, acc_b[7:1]};
    d_flags.n = 1'b0;
    d_flags.z = (d_result == 16'h0000);
    d_flags.c = acc_b[0];
    d_flags.v = d_flags.c;
  end
endmodule

/* File: hw/grade_calc.sv */
module grade_calc import smm_pkg::*;
(
  input wire logic [7:0] crisp,
  input wire logic [3:0][7:0] desc,
  output logic [7:0] grade
);
  logic [15:0] lead_prod;
  logic [15:0] trail_prod;
  logic [7:0] lead;
  logic [7:0] trail;

  always_comb
  begin
    lead_prod = desc[DSC_SLOPE_1] * (crisp - desc[DSC_POINT_1]);
    trail_prod = desc[DSC_SLOPE_2] * (desc[DSC_POINT_2] - crisp);
    // zero slope stands for a vertical side
    if (desc[DSC_SLOPE_1] == 8'h00 || lead_prod[15:8] != 8'h00)
      lead = 8'hff;
    else
      lead = lead_prod[7:0];
    if (desc[DSC_SLOPE_2] == 8'h00 || trail_prod[15:8] != 8'h00)
      trail = 8'hff;
    else
      trail = trail_prod[7:0];
    if (crisp < desc[DSC_POINT_1] || crisp > desc[DSC_POINT_2])
      grade = 8'h00;
    else
      grade = (lead < trail) ? lead : trail;
  end
endmodule

/* File: hw/smm_unit.sv */
// The AXI4-Lite slave port and the address map are this design's own decisions.
module smm_unit import smm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output mem_req_s mem_req,
  input wire mem_rsp_s mem_rsp
);
  typedef struct packed {
    state_e st;
    op_e op;
    logic err;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] x;
    logic [15:0] y;
    logic [7:0] condition_code_bits;
    logic [15:0] ea;
    logic [1:0] cnt;
    logic [3:0][7:0] desc;
    mem_req_s req;
    logic aw_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } unit_state_s;

  localparam unit_state_s STATE_RST = '{st: st_idle, op: op_none, condition_code_bits: CC_RST, default: '0};

  unit_state_s s;
  unit_state_s next_s;
  logic [7:0] b_shift;
  nzvc_s b_flags;
  logic [15:0] d_shift;
  nzvc_s d_flags;
  logic [7:0] grade;
  logic wr_go;
  logic [31:0] wr_old;
  logic wr_hit;
  logic [31:0] merged;
  logic [8:0] diff;
  nzvc_s mm_flags;
  op_e cmd_op;
  logic cmd_ok;
  logic [32:0] rd_word;

  function automatic logic [32:0] reg_read(input unit_state_s q, input logic [ADDR_W-1:0] addr);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (addr)
      OFS_ACC_D: r[15:0] = {q.a, q.b};
      OFS_INDEX_X: r[15:0] = q.x;
      OFS_INDEX_Y: r[15:0] = q.y;
      OFS_FLAGS: r[7:0] = q.condition_code_bits;
      OFS_OPER_ADDR: r[15:0] = q.ea;
      OFS_COMMAND:
      begin
        r[STAT_BUSY_BIT] = (q.st != st_idle);
        r[STAT_ERR_BIT] = q.err;
      end
      default: r[32] = 1'b0;
    endcase
    return r;
  endfunction

  right_shifter u_shift (
    .acc_a(s.a),
    .acc_b(s.b),
    .b_result(b_shift),
    .b_flags(b_flags),
    .d_result(d_shift),
    .d_flags(d_flags)
  );

  grade_calc u_grade (
    .crisp(s.a),
    .desc(s.desc),
    .grade(grade)
  );

  assign s_axi_awready = !s.aw_hold;
  assign s_axi_wready = !s.w_hold;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign mem_req = s.req;

  assign rd_word = reg_read(s, s_axi_araddr);
  assign wr_go = s.aw_hold && s.w_hold && !s.bvalid;
  assign {wr_hit, wr_old} = reg_read(s, s.aw_addr);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      merged[i*8 +: 8] = s.w_strb[i] ? s.w_data[i*8 +: 8] : wr_old[i*8 +: 8];
  end

  // flags of the internal difference A minus memory
  assign diff = {1'b0, s.a} - {1'b0, mem_rsp.rdata};
  assign mm_flags.n = diff[7];
  assign mm_flags.z = (diff[7:0] == 8'h00);
  assign mm_flags.v = (s.a[7] & ~mem_rsp.rdata[7] & ~diff[7]) | (~s.a[7] & mem_rsp.rdata[7] & diff[7]);
  assign mm_flags.c = diff[8];

  always_comb
  begin
    cmd_op = op_none;
    if (!merged[CMD_PREFIX_BIT])
    begin
      if (merged[7:0] == OPC_SHIFT_B)
        cmd_op = op_shift_right_second_acc;
      else if (merged[7:0] == OPC_SHIFT_D)
        cmd_op = op_shift_right_double_acc;
      else if (merged[7:0] == OPC_GRADE)
        cmd_op = op_grade_membership;
    end
    else if (merged[7:0] == OPC_MAX_A)
      cmd_op = op_max_to_accumulator;
    else if (merged[7:0] == OPC_MAX_M)
      cmd_op = op_max_to_memory;
    else if (merged[7:0] == OPC_MIN_A)
      cmd_op = op_min_to_accumulator;
    // a non-indexed mode on a max/min command is refused
    cmd_ok = (cmd_op != op_none) && (!merged[CMD_PREFIX_BIT] ||
      merged[CMD_MODE_LSB +: 3] <= MODE_LAST_INDEXED);
  end

  always_comb
  begin
    next_s = s;
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_awvalid && !s.aw_hold)
    begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_hold)
    begin
      next_s.w_hold = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s_axi_arvalid && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word[31:0];
      next_s.rresp = rd_word[32] ? RESP_OKAY : RESP_DECERR;
    end
    case (s.st)
      st_idle:
      begin
        if (wr_go)
        begin
          next_s.aw_hold = 1'b0;
          next_s.w_hold = 1'b0;
          next_s.bvalid = 1'b1;
          next_s.bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
          case (s.aw_addr)
            OFS_ACC_D: {next_s.a, next_s.b} = merged[15:0];
            OFS_INDEX_X: next_s.x = merged[15:0];
            OFS_INDEX_Y: next_s.y = merged[15:0];
            OFS_FLAGS: next_s.condition_code_bits = merged[7:0];
            OFS_OPER_ADDR: next_s.ea = merged[15:0];
            OFS_COMMAND:
            begin
              next_s.err = !cmd_ok;
              next_s.op = cmd_ok ? cmd_op : op_none;
              if (cmd_ok)
              begin
                case (cmd_op)
                  op_shift_right_second_acc:
                  begin
                    next_s.b = b_shift;
                    next_s.condition_code_bits[CC_N:CC_C] = b_flags;
                  end
                  op_shift_right_double_acc:
                  begin
                    {next_s.a, next_s.b} = d_shift;
                    next_s.condition_code_bits[CC_N:CC_C] = d_flags;
                  end
                  op_grade_membership:
                  begin
                    next_s.st = st_desc;
                    next_s.cnt = 2'h0;
                    next_s.req = '{valid: 1'b1, we: 1'b0, addr: s.x, wdata: 8'h00};
                  end
                  default:
                  begin
                    next_s.st = st_read;
                    next_s.req = '{valid: 1'b1, we: 1'b0, addr: s.ea, wdata: 8'h00};
                  end
                endcase
              end
            end
            default: next_s.bresp = RESP_DECERR;
          endcase
        end
      end
      st_read:
      begin
        if (mem_rsp.ack)
        begin
          next_s.condition_code_bits[CC_N:CC_C] = mm_flags;
          next_s.req.valid = 1'b0;
          next_s.st = st_idle;
          case (s.op)
            op_max_to_accumulator:
              next_s.a = mm_flags.c ? mem_rsp.rdata : s.a;
            op_min_to_accumulator:
              next_s.a = mm_flags.c ? s.a : mem_rsp.rdata;
            default:
            begin
              next_s.st = st_write;
              next_s.req.valid = 1'b1;
              next_s.req.we = 1'b1;
              next_s.req.wdata = mm_flags.c ? mem_rsp.rdata : s.a;
            end
          endcase
        end
      end
      st_desc:
      begin
        if (mem_rsp.ack)
        begin
          next_s.desc[s.cnt] = mem_rsp.rdata;
          next_s.cnt = s.cnt + 2'h1;
          next_s.req.addr = s.x + {14'h0000, s.cnt} + 16'h0001;
          if (s.cnt == 2'h3)
          begin
            next_s.req.valid = 1'b0;
            next_s.st = st_calc;
          end
        end
      end
      st_calc:
      begin
        // one idle cycle lets the last slope settle into the grade
        next_s.st = st_write;
        next_s.req = '{valid: 1'b1, we: 1'b1, addr: s.y, wdata: grade};
      end
      st_write:
      begin
        if (mem_rsp.ack)
        begin
          next_s.req.valid = 1'b0;
          next_s.req.we = 1'b0;
          next_s.st = st_idle;
          if (s.op == op_grade_membership)
          begin
            next_s.x = s.x + GRADE_X_STEP;
            next_s.y = s.y + GRADE_Y_STEP;
          end
        end
      end
      default: next_s.st = st_idle;
    endcase
    // register writes arriving while busy are answered with an error and dropped
    if (s.st != st_idle && wr_go)
    begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit ? RESP_SLVERR : RESP_DECERR;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      s <= STATE_RST;
    else
      s <= next_s;
  end

  logic cmd_go;
  logic reg_wr;
  assign reg_wr = wr_go && s.st == st_idle;
  assign cmd_go = reg_wr && s.aw_addr == OFS_COMMAND && cmd_ok;

  property p_shift_b;
    @(posedge clock) disable iff (!arst_n)
    cmd_go && cmd_op == op_shift_right_second_acc |=> s.b == {1'b0, $past(s.b[7:1])} && s.a == $past(s.a);
  endproperty
  a_shift_b: assert property (p_shift_b) else $error("second accumulator shift wrong");

  property p_shift_b_flags;
    @(posedge clock) disable iff (!arst_n)
    cmd_go && cmd_op == op_shift_right_second_acc |=> !s.condition_code_bits[CC_N]
      && s.condition_code_bits[CC_C] == $past(s.b[0]) && s.condition_code_bits[CC_Z] == (s.b == 8'h00)
      && s.condition_code_bits[CC_V] == s.condition_code_bits[CC_C];
  endproperty
  a_shift_b_flags: assert property (p_shift_b_flags) else $error("8-bit shift flags wrong");

  property p_shift_d;
    @(posedge clock) disable iff (!arst_n)
    cmd_go && cmd_op == op_shift_right_double_acc |=> {s.a, s.b} == {1'b0, $past(s.a), $past(s.b[7:1])}
      && s.condition_code_bits[CC_C] == $past(s.b[0]);
  endproperty
  a_shift_d: assert property (p_shift_d) else $error("double accumulator shift wrong");

  property p_shift_d_flags;
    @(posedge clock) disable iff (!arst_n)
    cmd_go && cmd_op == op_shift_right_double_acc |=> !s.condition_code_bits[CC_N]
      && s.condition_code_bits[CC_V] == s.condition_code_bits[CC_C]
      && s.condition_code_bits[CC_Z] == ({s.a, s.b} == 16'h0000);
  endproperty
  a_shift_d_flags: assert property (p_shift_d_flags) else $error("16-bit shift flags wrong");

  property p_max_a;
    @(posedge clock) disable iff (!arst_n)
    s.st == st_read && mem_rsp.ack && s.op == op_max_to_accumulator
      |=> s.a == ($past(mem_rsp.rdata) > $past(s.a) ? $past(mem_rsp.rdata) : $past(s.a));
  endproperty
  a_max_a: assert property (p_max_a) else $error("maximum not kept in A");

  property p_minmax_flags;
    @(posedge clock) disable iff (!arst_n)
    s.st == st_read && mem_rsp.ack |=> s.condition_code_bits[CC_C] == ($past(s.a) < $past(mem_rsp.rdata))
      && s.condition_code_bits[CC_Z] == ($past(s.a) == $past(mem_rsp.rdata));
  endproperty
  a_minmax_flags: assert property (p_minmax_flags) else $error("max/min flags wrong");

  property p_max_m;
    @(posedge clock) disable iff (!arst_n)
    s.st == st_read && mem_rsp.ack && s.op == op_max_to_memory |=> mem_req.valid && mem_req.we
      && mem_req.addr == $past(s.ea)
      && mem_req.wdata == ($past(mem_rsp.rdata) > $past(s.a) ? $past(mem_rsp.rdata) : $past(s.a));
  endproperty
  a_max_m: assert property (p_max_m) else $error("maximum not written to memory");

  property p_min_a;
    @(posedge clock) disable iff (!arst_n)
    s.st == st_read && mem_rsp.ack && s.op == op_min_to_accumulator
      |=> s.a == ($past(mem_rsp.rdata) < $past(s.a) ? $past(mem_rsp.rdata) : $past(s.a));
  endproperty
  a_min_a: assert property (p_min_a) else $error("minimum not kept in A");

  property p_grade_ptrs;
    @(posedge clock) disable iff (!arst_n)
    s.st == st_write && mem_rsp.ack && s.op == op_grade_membership
      |=> s.x == $past(s.x) + GRADE_X_STEP && s.y == $past(s.y) + GRADE_Y_STEP && s.a == $past(s.a);
  endproperty
  a_grade_ptrs: assert property (p_grade_ptrs) else $error("pointer update after grade wrong");

  property p_fixed_bits;
    @(posedge clock) disable iff (!arst_n)
    !reg_wr |=> s.condition_code_bits[CC_S] == $past(s.condition_code_bits[CC_S])
      && s.condition_code_bits[CC_X] == $past(s.condition_code_bits[CC_X])
      && s.condition_code_bits[CC_I] == $past(s.condition_code_bits[CC_I])
      && s.condition_code_bits[CC_H] == $past(s.condition_code_bits[CC_H]);
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("S, X, I or H changed");
endmodule

/* File: tb/mem_model.sv */
module mem_model import smm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] delay,
  input wire mem_req_s mem_req,
  output mem_rsp_s mem_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;
  logic [7:0] last;
  // outside an ack the data lines show the inverse of the last byte, so a stale sample never matches
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_rsp <= '0;
      cnt <= 4'h0;
      last <= 8'h00;
    end
    else if (mem_rsp.ack || !mem_req.valid)
    begin
      mem_rsp.ack <= 1'b0;
      mem_rsp.rdata <= ~last;
      cnt <= 4'h0;
    end
    else if (cnt < delay)
      cnt <= cnt + 4'h1;
    else
    begin
      mem_rsp.ack <= 1'b1;
      if (mem_req.we)
        mem[mem_req.addr] <= mem_req.wdata;
      else
      begin
        mem_rsp.rdata <= mem[mem_req.addr];
        last <= mem[mem_req.addr];
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
module tb_top import smm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, arst_n = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic awr, wr_rdy, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] delay = 4'h0;
  logic [1:0] br, rr;
  mem_req_s mreq;
  mem_rsp_s mrsp;
  int n_mismatch = 0, n_tests = 0;
  int ma, mb, mx, my, mf;
  logic [31:0] seed = 32'h00014589;

  smm_unit dut_u (.clock(clock), .arst_n(arst_n), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rd), .s_axi_rresp(rr), .mem_req(mreq), .mem_rsp(mrsp));
  mem_model mem_u (.clock(clock), .arst_n(arst_n), .delay(delay), .mem_req(mreq), .mem_rsp(mrsp));

  initial
  begin
    forever #25 clock = ~clock;
  end

  function automatic int rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[7:0]);
  endfunction

  function automatic void nzvc(input int n, input int z, input int v, input int c);
    mf = (mf & 32'hf0) | n * 8 | z * 4 | v * 2 | c;
  endfunction

  function automatic int grade(input int in, input int p1, input int p2, input int s1, input int s2);
    int l, t;
    if (in < p1 || in > p2)
      return 0;
    l = (s1 == 0) ? 255 : s1 * (in - p1);
    t = (s2 == 0) ? 255 : s2 * (p2 - in);
    l = (l < t) ? l : t;
    return (l > 255) ? 255 : l;
  endfunction

  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    $display("Error handshake expected answer seen none");
    conclude();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    chk(nm, {30'h0, e}, {30'h0, g});
  endtask

  // ready is sampled at the falling edge, where it has settled; transfers land on the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic ah, wh, bh;
    @(posedge clock);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    brd <= 1'b1;
    bh = 1'b0;
    for (k = 0; k < 200 && !bh; k++)
    begin
      @(negedge clock);
      ah = awv && awr;
      wh = wv && wr_rdy;
      bh = bv && brd;
      r = br;
      @(posedge clock);
      if (ah)
        awv <= 1'b0;
      if (wh)
        wv <= 1'b0;
    end
    brd <= 1'b0;
    if (!bh)
      hang();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ah, dh;
    @(posedge clock);
    arv <= 1'b1;
    ara <= a;
    rrd <= 1'b1;
    dh = 1'b0;
    for (k = 0; k < 200 && !dh; k++)
    begin
      @(negedge clock);
      ah = arv && arr;
      dh = rv && rrd;
      d = rd;
      r = rr;
      @(posedge clock);
      if (ah)
        arv <= 1'b0;
    end
    rrd <= 1'b0;
    if (!dh)
      hang();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk_resp("write response", RESP_OKAY, r);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(nm, e & m, d & m);
  endtask

  task automatic run(input logic [11:0] cmd);
    logic [31:0] d;
    logic [1:0] r;
    int k;
    wr(OFS_COMMAND, {20'h0, cmd});
    for (k = 0; k < 100; k++)
    begin
      axr(OFS_COMMAND, d, r);
      if (d[STAT_BUSY_BIT] === 1'b0)
        return;
    end
    hang();
  endtask

  task automatic load(input int a, input int b, input int f);
    ma = a;
    mb = b;
    mf = f;
    wr(OFS_ACC_D, 32'(a * 256 + b));
    wr(OFS_FLAGS, 32'(f));
  endtask

  // membership may alter h and nzvc, so only s, x and i are compared then
  task automatic check_regs(input bit cf);
    rdchk("acc d", OFS_ACC_D, 32'(ma * 256 + mb), 32'h0000ffff);
    rdchk("index x", OFS_INDEX_X, 32'(mx), 32'h0000ffff);
    rdchk("index y", OFS_INDEX_Y, 32'(my), 32'h0000ffff);
    rdchk("flags", OFS_FLAGS, 32'(mf), cf ? 32'h000000ff : 32'h000000d0);
  endtask

  initial
  begin
    int i, o, md, v, c, ea, mv, r8, k;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] opc [3];
    int tv [5][5];
    opc = '{OPC_MAX_A, OPC_MAX_M, OPC_MIN_A};
    tv = '{'{8'h40, 8'h20, 8'h80, 8'h04, 8'h04}, '{8'h20, 8'h20, 8'h80, 8'h00, 8'h02},
      '{8'h80, 8'h20, 8'h80, 8'h03, 8'h00}, '{8'h10, 8'h20, 8'h80, 8'h00, 8'h00},
      '{8'hc8, 8'h20, 8'h80, 8'h00, 8'h00}};
    // a real falling edge, so the asynchronous reset branch runs at all
    arst_n <= 1'b0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    ma = 0;
    mb = 0;
    mx = 0;
    my = 0;
    mf = 32'hd0;
    check_regs(1);
    $display("test reset values done");
    for (i = 0; i < 12; i++)
    begin
      v = (i < 2) ? 3 - 2 * i : rnd() * 256 + rnd();
      load(v >> 8, v & 255, rnd());
      run({4'h0, OPC_SHIFT_B});
      c = mb & 1;
      mb = mb >> 1;
      nzvc(0, mb == 0, c, c);
      check_regs(1);
      v = ma * 256 + mb;
      run({4'h0, OPC_SHIFT_D});
      c = v & 1;
      v = v >> 1;
      ma = v >> 8;
      mb = v & 255;
      nzvc(0, v == 0, c, c);
      check_regs(1);
    end
    $display("test shifts done");
    for (o = 0; o < 3; o++)
      for (md = 0; md < 5; md++)
      begin
        delay <= 4'(rnd() % 6);
        ea = rnd() * 256 + rnd();
        load(rnd(), rnd(), rnd());
        mv = (md == 2) ? ma : rnd();
        mem_u.mem[ea] = 8'(mv);
        wr(OFS_OPER_ADDR, 32'(ea));
        run({3'(md), 1'b1, opc[o]});
        r8 = (ma - mv) & 255;
        c = ma < mv;
        nzvc(r8 >> 7, r8 == 0, (((ma ^ mv) & (ma ^ r8)) >> 7) & 1, c);
        if ((o == 0 && c) || (o == 2 && !c))
          ma = mv;
        if (o == 1 && !c)
          mv = ma;
        check_regs(1);
        chk("memory byte", 32'(mv), {24'h0, mem_u.mem[ea]});
      end
    mem_u.mem[ea] = 8'h5a;
    run({3'h5, 1'b1, OPC_MAX_M});
    rdchk("refused status", OFS_COMMAND, 32'h2, 32'h3);
    check_regs(1);
    chk("memory untouched", 32'h5a, {24'h0, mem_u.mem[ea]});
    $display("test max and min done");
    for (i = 0; i < 10; i++)
    begin
      for (k = 0; k < 5; k++)
        tv[i % 5][k] = (i < 5) ? tv[i][k] : rnd();
      mx = rnd() * 256;
      my = (mx + 256 + rnd()) & 16'hffff;
      wr(OFS_INDEX_X, 32'(mx));
      wr(OFS_INDEX_Y, 32'(my));
      load(tv[i % 5][0], rnd(), rnd());
      for (k = 0; k < 4; k++)
        mem_u.mem[mx + k] = 8'(tv[i % 5][k + 1]);
      run({4'h0, OPC_GRADE});
      v = grade(tv[i % 5][0], tv[i % 5][1], tv[i % 5][2], tv[i % 5][3], tv[i % 5][4]);
      chk("grade", 32'(v), {24'h0, mem_u.mem[my]});
      mx = (mx + 4) & 16'hffff;
      my = (my + 1) & 16'hffff;
      check_regs(0);
    end
    $display("test membership done");
    axw(8'h1c, 32'h0, r);
    chk_resp("unmapped write", RESP_DECERR, r);
    axr(8'h3c, d, r);
    chk_resp("unmapped read", RESP_DECERR, r);
    $display("test unmapped done");
    conclude();
  end
endmodule
